// file: verilog/tccr_pkg.sv
// Purpose: Constants and types for the transceiver chain configuration bank
// Assumes: 8-bit register addresses, 16-bit register words
// Notes: Reset words follow the default column of each register
package tccr_pkg;

  // ==========================================================
  // Packet commands and address map
  localparam logic [7:0] TCCR_CMD_WRITE = 8'h10;
  localparam logic [7:0] TCCR_CMD_READ = 8'h20;
  localparam logic [7:0] TCCR_ADDR_INT_DIV = 8'h07;
  localparam logic [7:0] TCCR_ADDR_FRAC_DIV = 8'h08;
  localparam logic [7:0] TCCR_ADDR_BAND_PLL = 8'h09;
  localparam logic [7:0] TCCR_ADDR_CAL = 8'h0A;
  localparam logic [7:0] TCCR_ADDR_LPF = 8'h0B;
  localparam logic [7:0] TCCR_ADDR_RX_CTL = 8'h0C;
  localparam logic [7:0] TCCR_ADDR_TX_LIN = 8'h0D;
  localparam int TCCR_REG_COUNT = 7;
  localparam logic [15:0] TCCR_UNMAPPED_READ = 16'h0000;

  // ==========================================================
  // Array indexes (address minus first address)
  localparam logic [2:0] TCCR_IDX_INT = 3'h0;
  localparam logic [2:0] TCCR_IDX_FRAC = 3'h1;
  localparam logic [2:0] TCCR_IDX_BAND = 3'h2;
  localparam logic [2:0] TCCR_IDX_CAL = 3'h3;
  localparam logic [2:0] TCCR_IDX_LPF = 3'h4;
  localparam logic [2:0] TCCR_IDX_RXC = 3'h5;
  localparam logic [2:0] TCCR_IDX_TXL = 3'h6;

  // ==========================================================
  // Reset words
  localparam logic [15:0] TCCR_RST_INT = 16'h30A2;
  localparam logic [15:0] TCCR_RST_FRAC = 16'h1DDD;
  localparam logic [15:0] TCCR_RST_BAND = 16'h2024;
  localparam logic [15:0] TCCR_RST_CAL = 16'h1800;
  localparam logic [15:0] TCCR_RST_LPF = 16'h002A;
  localparam logic [15:0] TCCR_RST_RXC = 16'h0004;
  localparam logic [15:0] TCCR_RST_TXL = 16'h0200;
  localparam logic [6:0][15:0] TCCR_REG_RESET = {TCCR_RST_TXL, TCCR_RST_RXC, TCCR_RST_LPF,
    TCCR_RST_CAL, TCCR_RST_BAND, TCCR_RST_FRAC, TCCR_RST_INT};

  // ==========================================================
  // Field positions (low bit of each field)
  localparam int TCCR_POS_INT_WORD = 0;
  localparam int TCCR_POS_FRAC_LSB = 12;
  localparam int TCCR_POS_BAND_5G = 0;
  localparam int TCCR_POS_REF_DIV = 1;
  localparam int TCCR_POS_CP_4MA = 5;
  localparam int TCCR_POS_SUBBAND_HI = 6;
  localparam int TCCR_POS_AUTO_START = 7;
  localparam int TCCR_POS_SPI_BAND = 8;
  localparam int TCCR_POS_OSC_BAND = 9;
  localparam int TCCR_POS_MIMO = 13;
  localparam int TCCR_POS_CAL_RX = 0;
  localparam int TCCR_POS_CAL_TX = 1;
  localparam int TCCR_POS_CAL_GAIN = 11;
  localparam int TCCR_POS_RX_FINE = 0;
  localparam int TCCR_POS_RX_COARSE = 3;
  localparam int TCCR_POS_TX_COARSE = 5;
  localparam int TCCR_POS_RECEIVED_STRENGTH_INDICATOR_BW = 11;
  localparam int TCCR_POS_HP_CORNER = 2;
  localparam int TCCR_POS_RECEIVED_STRENGTH_INDICATOR_TEMP = 8;
  localparam int TCCR_POS_RECEIVED_STRENGTH_INDICATOR_ALWAYS = 10;
  localparam int TCCR_POS_RECEIVED_STRENGTH_INDICATOR_RANGE = 11;
  localparam int TCCR_POS_RX_GAIN_SER = 12;
  localparam int TCCR_POS_BB_GAIN = 0;
  localparam int TCCR_POS_UPC_BIAS = 2;
  localparam int TCCR_POS_TXVGA_BIAS = 6;
  localparam int TCCR_POS_PA_BIAS = 8;
  localparam int TCCR_POS_TX_GAIN_SER = 10;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    TCCR_ST_CMD = 3'h0,
    TCCR_ST_ADDR = 3'h1,
    TCCR_ST_DHI = 3'h2,
    TCCR_ST_DLO = 3'h3,
    TCCR_ST_TCMD = 3'h4,
    TCCR_ST_TADDR = 3'h5,
    TCCR_ST_THI = 3'h6,
    TCCR_ST_TLO = 3'h7
  } tccr_pkt_state_type;

  typedef struct packed {
    logic [7:0] int_word;
    logic [15:0] frac_word;
    logic [2:0] ref_div;
    logic cp_4ma;
    logic band_5g;
    logic subband_hi;
    logic band_auto_start;
    logic band_spi_mode;
    logic [1:0] tuned_oscillator_band;
    logic mimo_mode;
    logic [1:0] cal_tx_gain;
    logic cal_tx_en;
    logic cal_rx_en;
    logic received_strength_indicator_wide_bw;
    logic [1:0] tx_lowpass_coarse;
    logic [1:0] rx_lowpass_coarse;
    logic [2:0] rx_lowpass_fine;
    logic received_strength_indicator_enable;
    logic received_strength_indicator_high_range;
    logic received_strength_indicator_temp_out;
    logic rx_hp_corner_30k;
    logic [6:0] rx_gain;
    logic [5:0] tx_gain;
    logic [1:0] pa_bias;
    logic [1:0] txvga_bias;
    logic [1:0] upconv_bias;
    logic [1:0] bb_gain;
  } tccr_ctl_type;

endpackage

// file: verilog/tccr_bank.sv
// Purpose: Register bank of one transceiver chain, reached by control packets
// Assumes: Packet bytes come from logic on clk_sys; chip-side pins are asynchronous
// Notes: Decoded controls update on the edge that writes the register word; pin fields lag by the synchronisers
`timescale 1ns/100ps

module tccr_bank
  import tccr_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  // Packet stream from host
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // Packet stream to host
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Chip-side inputs (asynchronous)
  input wire logic rx_highpass_select,
  input wire logic [1:0] band_switch_state_machine_band,
  input wire logic [6:0] rx_gain_pins,
  input wire logic [5:0] tx_gain_pins,
  input wire logic [6:0] rx_gain_reg,
  input wire logic [5:0] tx_gain_reg,
  // Controls to the chain
  output tccr_ctl_type ctl,
  output logic [6:0][15:0] reg_image
);

  // ==========================================================
  // State
  typedef struct packed {
    tccr_pkt_state_type st;
    logic is_wr;
    logic is_rd;
    logic [7:0] addr;
    logic [7:0] dhi;
    logic [15:0] rdata;
    logic rx_ready;
    logic tx_valid;
    logic [7:0] tx_data;
    logic [6:0][15:0] regs;
    logic hp_s1;
    logic hp_s2;
    logic [1:0] fsm_s1;
    logic [1:0] fsm_s2;
    logic [6:0] rxp_s1;
    logic [6:0] rxp_s2;
    logic [5:0] txp_s1;
    logic [5:0] txp_s2;
    logic [6:0] rxr_s1;
    logic [6:0] rxr_s2;
    logic [5:0] txr_s1;
    logic [5:0] txr_s2;
    tccr_ctl_type ctl;
  } tccr_state_type;

  tccr_state_type s_q;
  tccr_state_type s_d;

  logic take;
  logic mapped;
  logic [7:0] offset;
  logic [2:0] idx;
  logic [15:0] wb, wi, wf, wc, wl, wr, wt;

  assign take = s_q.rx_ready && rx_valid;
  assign offset = s_q.addr - TCCR_ADDR_INT_DIV;
  assign idx = offset[2:0];
  assign mapped = (s_q.addr >= TCCR_ADDR_INT_DIV) && (s_q.addr <= TCCR_ADDR_TX_LIN);

  // Register fields decode from next state so controls track the image on the same edge
  // Pin fields read only the second synchroniser flop, never the first
  assign wi = s_d.regs[TCCR_IDX_INT];
  assign wf = s_d.regs[TCCR_IDX_FRAC];
  assign wb = s_d.regs[TCCR_IDX_BAND];
  assign wc = s_d.regs[TCCR_IDX_CAL];
  assign wl = s_d.regs[TCCR_IDX_LPF];
  assign wr = s_d.regs[TCCR_IDX_RXC];
  assign wt = s_d.regs[TCCR_IDX_TXL];

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    if (clk_en) begin
      // Two-flop synchronisers for pin inputs
      s_d.hp_s1 = rx_highpass_select;
      s_d.hp_s2 = s_q.hp_s1;
      s_d.fsm_s1 = band_switch_state_machine_band;
      s_d.fsm_s2 = s_q.fsm_s1;
      s_d.rxp_s1 = rx_gain_pins;
      s_d.rxp_s2 = s_q.rxp_s1;
      s_d.txp_s1 = tx_gain_pins;
      s_d.txp_s2 = s_q.txp_s1;
      s_d.rxr_s1 = rx_gain_reg;
      s_d.rxr_s2 = s_q.rxr_s1;
      s_d.txr_s1 = tx_gain_reg;
      s_d.txr_s2 = s_q.txr_s1;

      // Packet framing: unknown commands still consume four bytes to stay aligned
      unique case (s_q.st)
        TCCR_ST_CMD: begin
          if (take) begin
            s_d.is_wr = (rx_data == TCCR_CMD_WRITE);
            s_d.is_rd = (rx_data == TCCR_CMD_READ);
            s_d.st = TCCR_ST_ADDR;
          end
        end
        TCCR_ST_ADDR: begin
          if (take) begin
            s_d.addr = rx_data;
            s_d.st = TCCR_ST_DHI;
          end
        end
        TCCR_ST_DHI: begin
          if (take) begin
            s_d.dhi = rx_data;
            s_d.st = TCCR_ST_DLO;
          end
        end
        TCCR_ST_DLO: begin
          if (take) begin
            // Whole word stored, undocumented bits included
            if (s_q.is_wr && mapped) begin
              s_d.regs[idx] = {s_q.dhi, rx_data};
            end
            if (s_q.is_rd) begin
              s_d.rdata = mapped ? s_q.regs[idx] : TCCR_UNMAPPED_READ;
              s_d.rx_ready = 1'b0;
              s_d.tx_valid = 1'b1;
              s_d.tx_data = TCCR_CMD_READ;
              s_d.st = TCCR_ST_TCMD;
            end else begin
              s_d.st = TCCR_ST_CMD;
            end
          end
        end
        TCCR_ST_TCMD: begin
          if (tx_ready) begin
            s_d.tx_data = s_q.addr;
            s_d.st = TCCR_ST_TADDR;
          end
        end
        TCCR_ST_TADDR: begin
          if (tx_ready) begin
            s_d.tx_data = s_q.rdata[15:8];
            s_d.st = TCCR_ST_THI;
          end
        end
        TCCR_ST_THI: begin
          if (tx_ready) begin
            s_d.tx_data = s_q.rdata[7:0];
            s_d.st = TCCR_ST_TLO;
          end
        end
        TCCR_ST_TLO: begin
          if (tx_ready) begin
            s_d.tx_valid = 1'b0;
            s_d.rx_ready = 1'b1;
            s_d.st = TCCR_ST_CMD;
          end
        end
      endcase

      // Synthesizer
      s_d.ctl.int_word = wi[TCCR_POS_INT_WORD +: 8];
      s_d.ctl.frac_word = {wf[13:0], wi[TCCR_POS_FRAC_LSB +: 2]};
      s_d.ctl.ref_div = wb[TCCR_POS_REF_DIV +: 3];
      s_d.ctl.cp_4ma = wb[TCCR_POS_CP_4MA];
      s_d.ctl.band_5g = wb[TCCR_POS_BAND_5G];
      // Sub-range only meaningful in the upper band
      s_d.ctl.subband_hi = wb[TCCR_POS_BAND_5G] & wb[TCCR_POS_SUBBAND_HI];
      s_d.ctl.band_auto_start = wb[TCCR_POS_AUTO_START];
      s_d.ctl.band_spi_mode = wb[TCCR_POS_SPI_BAND];
      s_d.ctl.tuned_oscillator_band = wb[TCCR_POS_SPI_BAND] ? wb[TCCR_POS_OSC_BAND +: 2]
                                                            : s_q.fsm_s2;
      s_d.ctl.mimo_mode = wb[TCCR_POS_MIMO];
      // Calibration and filters
      s_d.ctl.cal_tx_gain = wc[TCCR_POS_CAL_GAIN +: 2];
      s_d.ctl.cal_tx_en = wc[TCCR_POS_CAL_TX];
      s_d.ctl.cal_rx_en = wc[TCCR_POS_CAL_RX];
      s_d.ctl.received_strength_indicator_wide_bw = wl[TCCR_POS_RECEIVED_STRENGTH_INDICATOR_BW];
      s_d.ctl.tx_lowpass_coarse = wl[TCCR_POS_TX_COARSE +: 2];
      s_d.ctl.rx_lowpass_coarse = wl[TCCR_POS_RX_COARSE +: 2];
      // Codes above 100 passed through; the chip defines nothing for them
      s_d.ctl.rx_lowpass_fine = wl[TCCR_POS_RX_FINE +: 3];
      // Receive control
      s_d.ctl.received_strength_indicator_enable = wr[TCCR_POS_RECEIVED_STRENGTH_INDICATOR_ALWAYS] | s_q.hp_s2;
      s_d.ctl.received_strength_indicator_high_range = wr[TCCR_POS_RECEIVED_STRENGTH_INDICATOR_RANGE];
      s_d.ctl.received_strength_indicator_temp_out = wr[TCCR_POS_RECEIVED_STRENGTH_INDICATOR_TEMP];
      s_d.ctl.rx_hp_corner_30k = wr[TCCR_POS_HP_CORNER];
      s_d.ctl.rx_gain = wr[TCCR_POS_RX_GAIN_SER] ? s_q.rxr_s2 : s_q.rxp_s2;
      // Transmit linearity
      s_d.ctl.tx_gain = wt[TCCR_POS_TX_GAIN_SER] ? s_q.txr_s2 : s_q.txp_s2;
      s_d.ctl.pa_bias = wt[TCCR_POS_PA_BIAS +: 2];
      s_d.ctl.txvga_bias = wt[TCCR_POS_TXVGA_BIAS +: 2];
      s_d.ctl.upconv_bias = wt[TCCR_POS_UPC_BIAS +: 2];
      s_d.ctl.bb_gain = wt[TCCR_POS_BB_GAIN +: 2];
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.regs <= TCCR_REG_RESET;
      s_q.rx_ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign rx_ready = s_q.rx_ready;
  assign tx_valid = s_q.tx_valid;
  assign tx_data = s_q.tx_data;
  assign ctl = s_q.ctl;
  assign reg_image = s_q.regs;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  logic pkt_end;
  assign pkt_end = clk_en && take && (s_q.st == TCCR_ST_DLO);

  // Controls are all zero in reset, so the five decode checks below start after an enabled edge
  frac_form_a: assert property (clk_en |=> s_q.ctl.frac_word ==
      {s_q.regs[TCCR_IDX_FRAC][13:0], s_q.regs[TCCR_IDX_INT][13:12]})
    else $error("fractional word not formed from both registers");

  osc_band_a: assert property (clk_en |=> s_q.ctl.tuned_oscillator_band ==
      (s_q.regs[TCCR_IDX_BAND][8] ? s_q.regs[TCCR_IDX_BAND][10:9] : $past(s_q.fsm_s2)))
    else $error("oscillator band source wrong");

  received_strength_indicator_mode_a: assert property (clk_en |=> s_q.ctl.received_strength_indicator_enable ==
      (s_q.regs[TCCR_IDX_RXC][10] | $past(s_q.hp_s2)))
    else $error("indicator enable wrong");

  rx_gain_a: assert property (clk_en |=> s_q.ctl.rx_gain ==
      (s_q.regs[TCCR_IDX_RXC][12] ? $past(s_q.rxr_s2) : $past(s_q.rxp_s2)))
    else $error("receive gain source wrong");

  tx_gain_a: assert property (clk_en |=> s_q.ctl.tx_gain ==
      (s_q.regs[TCCR_IDX_TXL][10] ? $past(s_q.txr_s2) : $past(s_q.txp_s2)))
    else $error("transmit gain source wrong");

  write_store_a: assert property ((pkt_end && s_q.is_wr && mapped) |=>
      (s_q.regs[$past(idx)] == {$past(s_q.dhi), $past(rx_data)}))
    else $error("written word not stored");

  read_reply_a: assert property ((pkt_end && s_q.is_rd) |=>
      (tx_valid && !rx_ready && tx_data == TCCR_CMD_READ))
    else $error("read reply did not start");

  reply_hold_a: assert property ((tx_valid && !tx_ready) |=>
      (tx_valid && $stable(tx_data)))
    else $error("reply byte dropped under stall");

  reply_len_a: assert property ((pkt_end && s_q.is_rd && tx_ready) ##1 (clk_en && tx_ready) [*4]
      |=> (!tx_valid && rx_ready))
    else $error("reply not four bytes");

  subband_a: assert property (s_q.ctl.subband_hi |-> s_q.ctl.band_5g)
    else $error("sub-range active outside upper band");

  write_cov: cover property (pkt_end && s_q.is_wr && mapped);
  read_cov: cover property (pkt_end && s_q.is_rd ##[1:20] (s_q.st == TCCR_ST_TLO && tx_ready));
  stall_cov: cover property (tx_valid && !tx_ready ##1 tx_valid && tx_ready);

endmodule

// file: test/tccr_host_model.sv
// Purpose: Host side of the packet port, taking reply bytes from the bank
// Assumes: Replies are four bytes on tx_valid and tx_ready
// Notes: Slow mode drops tx_ready on every other cycle so stalls are exercised
`timescale 1ns/100ps

module tccr_host_model
  import tccr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Pacing
  input wire logic slow,
  // Reply stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Collected bytes
  output logic [31:0] reply,
  output logic [15:0] taken
);
  // ==========================================================
  // Reply intake, bytes shifted in as sent
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_ready <= 1'b0;
      reply <= 32'h0;
      taken <= 16'h0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        reply <= {reply[23:0], tx_data};
        taken <= taken + 16'h1;
      end
    end
  end
endmodule

// file: test/tccr_bank_tb_top.sv
// Purpose: Packet-level tests of the transceiver chain register bank
// Assumes: clk_en high except one freeze check; host model takes reply bytes
// Notes: Inputs change on the falling edge only
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end

module tccr_bank_tb_top;
  import tccr_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic slow = 1'b0;
  logic clk_en = 1'b1;
  logic keep_valid = 1'b0;
  logic hp_sel = 1'b0;
  logic [1:0] sm_band = 2'h1;
  logic [6:0] rx_pins = 7'h15;
  logic [6:0] rx_reg = 7'h6A;
  logic [5:0] tx_pins = 6'h0C;
  logic [5:0] tx_reg = 6'h33;
  logic rx_ready, tx_valid, tx_ready;
  logic [7:0] tx_data;
  tccr_ctl_type ctl;
  logic [6:0][15:0] reg_image, saved;
  logic [31:0] reply;
  logic [15:0] taken, w;
  int errors = 0;
  int samples_checked = 0;
  localparam logic [6:0][15:0] RST_WORDS = {16'h0200, 16'h0004, 16'h002A, 16'h1800, 16'h2024, 16'h1DDD, 16'h30A2};

  always #20 clk_sys = ~clk_sys;

  tccr_bank tccr_bank_inst (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .rx_highpass_select(hp_sel), .band_switch_state_machine_band(sm_band), .rx_gain_pins(rx_pins),
    .tx_gain_pins(tx_pins), .rx_gain_reg(rx_reg), .tx_gain_reg(tx_reg), .ctl(ctl), .reg_image(reg_image));

  tccr_host_model tccr_host_model_inst (.clk_sys(clk_sys), .reset_n(reset_n), .slow(slow), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .reply(reply), .taken(taken));

  // ==========================================================
  // Packet tasks
  task automatic send_byte(input logic [7:0] b);
    int n;
    begin
      n = 0;
      rx_valid = 1'b1;
      rx_data = b;
      // Ready judged at the falling edge, where it has settled
      while (rx_ready !== 1'b1 && n < 50) begin
        n++;
        @(negedge clk_sys);
      end
      if (n == 50) begin
        errors++;
      end
      @(negedge clk_sys);
    end
  endtask

  task automatic send_pkt(input logic [7:0] cmd, input logic [7:0] addr, input logic [15:0] data);
    begin
      send_byte(cmd);
      send_byte(addr);
      send_byte(data[15:8]);
      send_byte(data[7:0]);
      if (!keep_valid) begin
        rx_valid = 1'b0;
        // Released bus shows a changed value, never the last byte
        rx_data = ~data[7:0];
        // One idle edge so the strobe never drops and rises in one step
        @(negedge clk_sys);
      end
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [15:0] data);
    send_pkt(TCCR_CMD_WRITE, addr, data);
  endtask

  task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
    logic [15:0] t;
    int n;
    begin
      t = taken;
      n = 0;
      send_pkt(TCCR_CMD_READ, addr, 16'h0000);
      `CHK("rx_ready in reply", 1'b0, rx_ready)
      while (taken !== t + 16'h4 && n < 100) begin
        n++;
        @(negedge clk_sys);
      end
      if (n == 100) begin
        errors++;
      end
      `CHK("reply", {8'h20, addr, exp}, reply)
    end
  endtask

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    errors++;
    tally_and_finish();
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (8) @(negedge clk_sys);
    reset_n = 1'b1;
    @(negedge clk_sys);
    `CHK("reset image", RST_WORDS, reg_image)
    `CHK("cp reset", 1'b1, ctl.cp_4ma)
    `CHK("cal reset", 2'b00, {ctl.cal_tx_en, ctl.cal_rx_en})
    `CHK("mimo reset", 1'b1, ctl.mimo_mode)
    for (int i = 0; i < 7; i++) begin
      slow = i[0];
      rd(TCCR_ADDR_INT_DIV + 8'(i), RST_WORDS[i]);
    end
    slow = 1'b0;
    // Back-to-back writes; top bits have no function but must store
    for (int i = 0; i < 7; i++) begin
      keep_valid = (i < 6);
      wr(TCCR_ADDR_INT_DIV + 8'(i), 16'hC3A0 + 16'(i) * 16'h0111);
    end
    for (int i = 0; i < 7; i++) begin
      w = 16'hC3A0 + 16'(i) * 16'h0111;
      `CHK("image", w, reg_image[i])
      rd(TCCR_ADDR_INT_DIV + 8'(i), w);
    end
    saved = reg_image;
    wr(8'h06, 16'hFFFF);
    wr(8'h0E, 16'hFFFF);
    send_pkt(8'h33, TCCR_ADDR_INT_DIV, 16'h1234);
    `CHK("no reply", 1'b0, tx_valid)
    `CHK("image kept", saved, reg_image)
    rd(8'h0E, 16'h0000);
    // Divider words
    wr(TCCR_ADDR_INT_DIV, 16'h2080);
    wr(TCCR_ADDR_FRAC_DIV, 16'hEABC);
    `CHK("int word", 8'h80, ctl.int_word)
    `CHK("frac word", {14'h2ABC, 2'b10}, ctl.frac_word)
    wr(TCCR_ADDR_INT_DIV, 16'h10FF);
    `CHK("frac low", {14'h2ABC, 2'b01}, ctl.frac_word)
    `CHK("int top", 8'hFF, ctl.int_word)
    // Band and PLL, programmed then state machine band
    wr(TCCR_ADDR_BAND_PLL, 16'h05CB);
    `CHK("osc band spi", 2'b10, ctl.tuned_oscillator_band)
    `CHK("spi mode", 1'b1, ctl.band_spi_mode)
    `CHK("auto", 1'b1, ctl.band_auto_start)
    `CHK("subband", 1'b1, ctl.subband_hi)
    `CHK("cp", 1'b0, ctl.cp_4ma)
    `CHK("ref div", 3'h5, ctl.ref_div)
    `CHK("band 5g", 1'b1, ctl.band_5g)
    `CHK("mimo off", 1'b0, ctl.mimo_mode)
    wr(TCCR_ADDR_BAND_PLL, 16'h066E);
    `CHK("osc band sm", sm_band, ctl.tuned_oscillator_band)
    `CHK("auto off", 1'b0, ctl.band_auto_start)
    `CHK("subband 2g", 1'b0, ctl.subband_hi)
    `CHK("cp 4ma", 1'b1, ctl.cp_4ma)
    `CHK("ref div 7", 3'h7, ctl.ref_div)
    `CHK("band 2g", 1'b0, ctl.band_5g)
    sm_band = 2'h2;
    repeat (3) @(negedge clk_sys);
    `CHK("osc band follow", 2'h2, ctl.tuned_oscillator_band)
    // Enable low freezes synchronisers and controls
    clk_en = 1'b0;
    sm_band = 2'h3;
    repeat (4) @(negedge clk_sys);
    `CHK("osc band frozen", 2'h2, ctl.tuned_oscillator_band)
    clk_en = 1'b1;
    repeat (3) @(negedge clk_sys);
    `CHK("osc band resumed", 2'h3, ctl.tuned_oscillator_band)
    // Every code of the two-bit fields
    for (int i = 0; i < 5; i++) begin
      hp_sel = (i == 2);
      repeat (3) @(negedge clk_sys);
      wr(TCCR_ADDR_CAL, 16'(i % 4) << 11 | 16'(i % 4));
      `CHK("cal gain", 2'(i), ctl.cal_tx_gain)
      `CHK("cal en", 2'(i), {ctl.cal_tx_en, ctl.cal_rx_en})
      wr(TCCR_ADDR_LPF, 16'(i % 2) << 11 | 16'(i % 4) << 5 | 16'(i % 4) << 3 | 16'(i));
      `CHK("received_strength_indicator bw", 1'(i), ctl.received_strength_indicator_wide_bw)
      `CHK("tx lpf", 2'(i), ctl.tx_lowpass_coarse)
      `CHK("rx lpf", 2'(i), ctl.rx_lowpass_coarse)
      `CHK("rx fine", 3'(i), ctl.rx_lowpass_fine)
      wr(TCCR_ADDR_RX_CTL, 16'((i / 2) % 2) << 12 | 16'(i % 2) << 11 | 16'(i % 2) << 10 |
        16'((i / 2) % 2) << 8 | 16'(i % 2) << 2);
      `CHK("received_strength_indicator range", 1'(i), ctl.received_strength_indicator_high_range)
      `CHK("received_strength_indicator temp", 1'((i / 2) % 2), ctl.received_strength_indicator_temp_out)
      `CHK("rx gain", ((i / 2) % 2) ? rx_reg : rx_pins, ctl.rx_gain)
      `CHK("received_strength_indicator en", 1'(i) | hp_sel, ctl.received_strength_indicator_enable)
      `CHK("hp corner", 1'(i), ctl.rx_hp_corner_30k)
      wr(TCCR_ADDR_TX_LIN, 16'(i % 2) << 10 | 16'(i % 4) * 16'h0145);
      `CHK("tx gain", (i % 2) ? tx_reg : tx_pins, ctl.tx_gain)
      `CHK("bias", {3{2'(i)}}, {ctl.pa_bias, ctl.txvga_bias, ctl.upconv_bias})
      `CHK("bb gain", 2'(i), ctl.bb_gain)
    end
    tally_and_finish();
  end
endmodule
